// ==== include/mode_ctl_params.svh ====
// Constants for the operating-mode and system-control block.
// Assumes inclusion by bare name from the design files.
`ifndef MODE_CTL_PARAMS_SVH
`define MODE_CTL_PARAMS_SVH
`define MC_ADDR_MODE_STATUS   16'hFFF1
`define MC_ADDR_SYS_CTRL      16'hFFF2
`define MC_SYS_CTRL_RESET     8'h0B
`define MC_MODE_FIXED_BITS    8'hC4
`define MC_SYS_CTRL_WMASK     8'hFD
`define MC_SYS_CTRL_FIXED1    8'h02
`define MC_BIT_DEEP_STANDBY   7
`define MC_BIT_SETTLE_HI      6
`define MC_BIT_SETTLE_LO      4
`define MC_BIT_USER_FLAG_SEL  3
`define MC_BIT_NMI_EDGE       2
`define MC_BIT_RAM_ON         0
`define MC_SETTLE_BASE        18'h02000
`define MC_RAM_FILL           8'hFF
`define MC_MEM_STATES         2'h2
`define MC_PERIPH_STATES      2'h3
`define MC_AREA_COUNT         8
`endif

// ==== include/mode_ctl_pkg.sv ====
// Types shared by the mode and system-control design.
// Assumes nothing of its surroundings.
package mode_ctl_pkg;
    typedef enum logic [3:0] {
        ST_RUN     = 4'h1,
        ST_SLEEP   = 4'h2,
        ST_STANDBY = 4'h4,
        ST_SETTLE  = 4'h8
    } power_state_t;
    typedef enum logic [1:0] {
        MODE_NONE = 2'h0,
        MODE_EXP  = 2'h1,
        MODE_64K  = 2'h2,
        MODE_1M   = 2'h3
    } op_mode_t;
endpackage

// ==== hw/settle_timer.sv ====
// Oscillator settle counter used after leaving deep standby.
// Assumes a start pulse and a stable select code while counting.
`include "mode_ctl_params.svh"
module settle_timer #(
    parameter int CW = 18
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [2:0]  i_sel,
    output logic             o_done
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          done_r;
    logic          done_nxt;

    // Length is base states shifted by code; codes 1xx share the longest.
    function automatic logic [CW-1:0] settle_len(input logic [2:0] s);
        logic [2:0] sh;
        sh = s[2] ? 3'h4 : {1'b0, s[1:0]};
        settle_len = CW'(`MC_SETTLE_BASE) << sh;
    endfunction

    always_comb begin
        cnt_nxt  = cnt_r;
        done_nxt = 1'b0;
        if (i_start) begin
            cnt_nxt = settle_len(i_sel) - CW'(1); // R11
        end else if (cnt_r != '0) begin
            cnt_nxt  = cnt_r - CW'(1);
            done_nxt = (cnt_r == CW'(1));
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_done = done_r;
endmodule

// ==== hw/mode_ctl.sv ====
// Operating-mode status and system-control registers with the derived
// memory, bus and power controls.
// Assumes a core-side register port with a one-cycle strobe per access and
// that the mode straps are synchronous and held steady while running.
`include "mode_ctl_params.svh"

// Summary of operation
// [R01] On-chip memory: two states, 16-bit path.
// [R02] Peripheral registers: three states, 8/16-bit; the code always drives an 8-bit path.
// [R03] Eight external areas, width and states each.
// [R04] Strap pattern selects mode one, two, three.
// [R05] Straps valid and steady during operation.
// [R06] Mode 1, RAM off: RAM range external.
// [R07] Modes 2/3, RAM off: reads FF, writes dropped.
// [R08] Mode status read-only, fixed upper bits.
// [R09] Low status bits latch straps on read.
// [R10] Standby bit picks sleep or deep standby.
// [R11] Settle select sets post-standby wait length.
// [R12] Software keeps settle wait above eight ms.
// [R13] User flag select: mask or user bit.
// [R14] Edge select picks nonmaskable request edge.
// [R15] RAM on set at reset, kept in standby.
// [R16] System control reads back, reset 0B, bit1 one.
// [R17] Mode 1: port 3 data, ports address.
// [R18] Modes 2/3: no external bus accesses.
// [R19] Trap entry sets mask, user flag conditionally.
// [R20] Reserved and read-only writes ignored.
module mode_ctl #(
    parameter int AREAS = `MC_AREA_COUNT
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic             i_mode_strap_hi,
    input  wire logic             i_mode_strap_lo,
    input  wire logic             i_reg_sel,
    input  wire logic             i_reg_wr,
    input  wire logic [15:0]      i_reg_addr,
    input  wire logic [7:0]       i_reg_wdata,
    input  wire logic             i_sleep_insn,
    input  wire logic             i_ext_wake,
    input  wire logic             i_exc_entry,
    input  wire logic             i_ram_range,
    input  wire logic             i_periph_range,
    input  wire logic             i_ext_range,
    input  wire logic [2:0]       i_ext_area,
    input  wire logic [AREAS-1:0] i_area_wide,
    input  wire logic [AREAS-1:0] i_area_three,
    input  wire logic [7:0]       i_port_dir,
    output logic [7:0]            o_reg_rdata,
    output logic                  o_reg_ack,
    output logic [1:0]            o_access_states,
    output logic                  o_access_wide,
    output logic                  o_ram_active,
    output logic                  o_ram_read_fill,
    output logic                  o_ext_access,
    output logic                  o_addr_64k,
    output logic                  o_port3_databus,
    output logic [7:0]            o_port_addr_en,
    output logic                  o_set_int_mask,
    output logic                  o_set_user_or_mask_flag,
    output logic                  o_user_flag_is_mask,
    output logic                  o_nonmaskable_rising,
    output logic                  o_clock_halted,
    output logic                  o_core_stopped
);
    // ==========================================================
    // Register file
    // ==========================================================
    logic [7:0] sys_ctrl_r, sys_ctrl_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       ack_r, ack_nxt;
    mode_ctl_pkg::op_mode_t mode;

    assign mode = mode_ctl_pkg::op_mode_t'({i_mode_strap_hi, i_mode_strap_lo}); // R04 R05

    function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
        hit = (a == r);
    endfunction

    always_comb begin
        sys_ctrl_nxt   = sys_ctrl_r;
        rdata_nxt      = 8'h00;
        ack_nxt        = i_reg_sel;
        if (i_reg_sel && i_reg_wr && hit(i_reg_addr, `MC_ADDR_SYS_CTRL)) begin
            sys_ctrl_nxt = (i_reg_wdata & `MC_SYS_CTRL_WMASK) | `MC_SYS_CTRL_FIXED1; // R16 R20
        end
        if (i_reg_sel && !i_reg_wr && hit(i_reg_addr, `MC_ADDR_MODE_STATUS)) begin
            rdata_nxt = `MC_MODE_FIXED_BITS | {6'h00, i_mode_strap_hi, i_mode_strap_lo}; // R08 R09
        end
        if (i_reg_sel && !i_reg_wr && hit(i_reg_addr, `MC_ADDR_SYS_CTRL)) begin
            rdata_nxt = sys_ctrl_r | `MC_SYS_CTRL_FIXED1; // R16
        end
    end

    // Reset path is the released reset pin; standby never touches this.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sys_ctrl_r   <= `MC_SYS_CTRL_RESET; // R15 R16
            rdata_r      <= 8'h00;
            ack_r        <= 1'b0;
        end else begin
            sys_ctrl_r   <= sys_ctrl_nxt;
            rdata_r      <= rdata_nxt;
            ack_r        <= ack_nxt;
        end
    end

    logic       deep_standby_enable;
    logic [2:0] osc_settle_sel;
    logic       user_flag_select;
    logic       nonmaskable_edge_sel;
    logic       onchip_ram_on;
    assign deep_standby_enable  = sys_ctrl_r[`MC_BIT_DEEP_STANDBY];
    assign osc_settle_sel       = sys_ctrl_r[`MC_BIT_SETTLE_HI:`MC_BIT_SETTLE_LO];
    assign user_flag_select     = sys_ctrl_r[`MC_BIT_USER_FLAG_SEL];
    assign nonmaskable_edge_sel = sys_ctrl_r[`MC_BIT_NMI_EDGE];
    assign onchip_ram_on        = sys_ctrl_r[`MC_BIT_RAM_ON];

    // ==========================================================
    // Power state
    // ==========================================================
    mode_ctl_pkg::power_state_t pst_r, pst_nxt;
    logic settle_start;
    logic settle_done;

    settle_timer u_settle (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_start (settle_start),
        .i_sel   (osc_settle_sel),
        .o_done  (settle_done)
    );

    always_comb begin
        pst_nxt      = pst_r;
        settle_start = 1'b0;
        unique case (pst_r)
            mode_ctl_pkg::ST_RUN: begin
                if (i_sleep_insn) begin
                    pst_nxt = deep_standby_enable ? mode_ctl_pkg::ST_STANDBY
                                                  : mode_ctl_pkg::ST_SLEEP; // R10
                end
            end
            mode_ctl_pkg::ST_SLEEP: begin
                if (i_ext_wake) begin
                    pst_nxt = mode_ctl_pkg::ST_RUN;
                end
            end
            mode_ctl_pkg::ST_STANDBY: begin
                if (i_ext_wake) begin
                    pst_nxt      = mode_ctl_pkg::ST_SETTLE;
                    settle_start = 1'b1; // R11
                end
            end
            mode_ctl_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    pst_nxt = mode_ctl_pkg::ST_RUN;
                end
            end
            default: pst_nxt = mode_ctl_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pst_r <= mode_ctl_pkg::ST_RUN;
        end else begin
            pst_r <= pst_nxt;
        end
    end

    // ==========================================================
    // Access routing and derived controls
    // ==========================================================
    logic [1:0] states_nxt, states_r;
    logic       wide_nxt, wide_r;
    logic       ram_act_nxt, ram_act_r;
    logic       fill_nxt, fill_r;
    logic       ext_nxt, ext_r;
    logic       expanded;
    logic [7:0] ctl_r, ctl_nxt;

    assign expanded = (mode == mode_ctl_pkg::MODE_EXP);

    always_comb begin
        states_nxt  = 2'h0;
        wide_nxt    = 1'b0;
        ram_act_nxt = 1'b0;
        fill_nxt    = 1'b0;
        ext_nxt     = 1'b0;
        if (i_ram_range && onchip_ram_on) begin
            states_nxt  = `MC_MEM_STATES; // R01
            wide_nxt    = 1'b1;
            ram_act_nxt = 1'b1;
        end else if (i_ram_range && expanded) begin
            ext_nxt    = 1'b1; // R06
            states_nxt = i_area_three[i_ext_area] ? `MC_PERIPH_STATES : `MC_MEM_STATES;
            wide_nxt   = i_area_wide[i_ext_area];
        end else if (i_ram_range) begin
            fill_nxt   = 1'b1; // R07
            states_nxt = `MC_MEM_STATES;
        end else if (i_periph_range) begin
            states_nxt = `MC_PERIPH_STATES; // R02
            wide_nxt   = 1'b0;
        end else if (i_ext_range && expanded) begin
            ext_nxt    = 1'b1; // R03 R18
            states_nxt = i_area_three[i_ext_area] ? `MC_PERIPH_STATES : `MC_MEM_STATES;
            wide_nxt   = i_area_wide[i_ext_area];
        end
        ctl_nxt = {mode == mode_ctl_pkg::MODE_64K, // R18
                   expanded,                        // R17
                   i_exc_entry,                     // R19
                   i_exc_entry && !user_flag_select, // R19
                   !user_flag_select,               // R13
                   nonmaskable_edge_sel,            // R14
                   pst_r == mode_ctl_pkg::ST_STANDBY || pst_r == mode_ctl_pkg::ST_SETTLE,
                   pst_r != mode_ctl_pkg::ST_RUN};
    end

    logic [7:0] paddr_r, paddr_nxt;
    assign paddr_nxt = expanded ? i_port_dir : 8'h00; // R17

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            states_r  <= 2'h0;
            wide_r    <= 1'b0;
            ram_act_r <= 1'b0;
            fill_r    <= 1'b0;
            ext_r     <= 1'b0;
            ctl_r     <= 8'h00;
            paddr_r   <= 8'h00;
        end else begin
            states_r  <= states_nxt;
            wide_r    <= wide_nxt;
            ram_act_r <= ram_act_nxt;
            fill_r    <= fill_nxt;
            ext_r     <= ext_nxt;
            ctl_r     <= ctl_nxt;
            paddr_r   <= paddr_nxt;
        end
    end

    assign o_reg_rdata             = rdata_r;
    assign o_reg_ack               = ack_r;
    assign o_access_states         = states_r;
    assign o_access_wide           = wide_r;
    assign o_ram_active            = ram_act_r;
    assign o_ram_read_fill         = fill_r;
    assign o_ext_access            = ext_r;
    assign o_addr_64k              = ctl_r[7];
    assign o_port3_databus         = ctl_r[6];
    assign o_set_int_mask          = ctl_r[5];
    assign o_set_user_or_mask_flag = ctl_r[4];
    assign o_user_flag_is_mask     = ctl_r[3];
    assign o_nonmaskable_rising    = ctl_r[2];
    assign o_clock_halted          = ctl_r[1];
    assign o_core_stopped          = ctl_r[0];
    assign o_port_addr_en          = paddr_r;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_status_read;
        @(posedge i_clk) disable iff (i_rst)
        (i_reg_sel && !i_reg_wr && i_reg_addr == `MC_ADDR_MODE_STATUS) |=>
        (o_reg_rdata == (`MC_MODE_FIXED_BITS |
                         {6'h00, $past(i_mode_strap_hi), $past(i_mode_strap_lo)}));
    endproperty
    a_status_read: assert property (p_status_read) else $error("bad mode status"); // R09

    property p_bit1;
        @(posedge i_clk) disable iff (i_rst)
        (i_reg_sel && !i_reg_wr && i_reg_addr == `MC_ADDR_SYS_CTRL) |=> o_reg_rdata[1];
    endproperty
    a_bit1: assert property (p_bit1) else $error("reserved bit low"); // R16

    property p_fill;
        @(posedge i_clk) disable iff (i_rst)
        (i_ram_range && !onchip_ram_on && !expanded) |=> (o_ram_read_fill && !o_ext_access);
    endproperty
    a_fill: assert property (p_fill) else $error("ram fill missing"); // R07

    property p_no_ext;
        @(posedge i_clk) disable iff (i_rst) (!expanded) |=> !o_ext_access;
    endproperty
    a_no_ext: assert property (p_no_ext) else $error("external access in single"); // R18

    property p_periph;
        @(posedge i_clk) disable iff (i_rst)
        (i_periph_range && !i_ram_range) |=> (o_access_states == `MC_PERIPH_STATES);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral states"); // R02

    property p_ram;
        @(posedge i_clk) disable iff (i_rst)
        (i_ram_range && onchip_ram_on) |=> (o_access_states == `MC_MEM_STATES && o_access_wide);
    endproperty
    a_ram: assert property (p_ram) else $error("memory states"); // R01

    property p_sleep;
        @(posedge i_clk) disable iff (i_rst)
        (pst_r == mode_ctl_pkg::ST_RUN && i_sleep_insn) |=> ##1
        (o_clock_halted == $past(deep_standby_enable, 2) && o_core_stopped);
    endproperty
    a_sleep: assert property (p_sleep) else $error("wrong power state"); // R10

    property p_user;
        @(posedge i_clk) disable iff (i_rst)
        i_exc_entry |=> (o_set_int_mask && o_set_user_or_mask_flag == !$past(user_flag_select));
    endproperty
    a_user: assert property (p_user) else $error("flag set wrong"); // R19

    property p_ram_kept;
        @(posedge i_clk) disable iff (i_rst)
        (pst_r == mode_ctl_pkg::ST_STANDBY && !i_reg_sel) |=> $stable(onchip_ram_on);
    endproperty
    a_ram_kept: assert property (p_ram_kept) else $error("ram enable lost"); // R15

    c_standby: cover property (@(posedge i_clk) pst_r == mode_ctl_pkg::ST_SETTLE ##1
                               pst_r == mode_ctl_pkg::ST_RUN);
    c_fill: cover property (@(posedge i_clk) o_ram_read_fill);
    c_ext: cover property (@(posedge i_clk) o_ext_access && o_access_states == `MC_PERIPH_STATES);
endmodule

// ==== tb/strap_core_model.sv ====
// Model of the mode strap pins seen by the mode and system-control block.
// Assumes the bench asks for a mode number and pulses reset around changes.
module strap_core_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_mode_req,
    output logic            o_strap_hi,
    output logic            o_strap_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] level = 2'h3;
    // The straps only follow a new request while the chip is held in reset.
    always @(posedge i_clk) begin
        if (i_rst && i_mode_req != 2'h0) begin
            level <= i_mode_req;
        end
    end
    assign o_strap_hi = level[1];
    assign o_strap_lo = level[0];
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the mode and system-control block.
// Assumes the design files, the package and the constants header are compiled first.
`include "mode_ctl_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'b0, i_rst = 1'b1, i_reg_sel = 1'b0, i_reg_wr = 1'b0;
    logic i_sleep_insn = 1'b0, i_ext_wake = 1'b0, i_exc_entry = 1'b0;
    logic i_ram_range = 1'b0, i_periph_range = 1'b0, i_ext_range = 1'b0;
    logic [15:0] i_reg_addr = 16'h0000;
    logic [7:0] i_reg_wdata = 8'h00, i_area_wide = 8'h00, i_area_three = 8'h00;
    logic [7:0] i_port_dir = 8'h00, o_reg_rdata, o_port_addr_en, wv;
    logic [2:0] i_ext_area = 3'h0;
    logic [1:0] mode_req = 2'h1, o_access_states;
    logic hi, lo, o_reg_ack, o_access_wide, o_ram_active, o_ram_read_fill, o_ext_access;
    logic o_addr_64k, o_port3_databus, o_set_int_mask, o_set_user_or_mask_flag;
    logic o_user_flag_is_mask, o_nonmaskable_rising, o_clock_halted, o_core_stopped;
    logic [8:0] exp_q[$];
    logic [8:0] note;
    int n_mismatch = 0, checks_done = 0, n, seed_v;

    always #25 i_clk = ~i_clk;

    strap_core_model straps (.i_clk(i_clk), .i_rst(i_rst), .i_mode_req(mode_req),
        .o_strap_hi(hi), .o_strap_lo(lo));

    mode_ctl DUT (.i_clk(i_clk), .i_rst(i_rst), .i_mode_strap_hi(hi), .i_mode_strap_lo(lo),
        .i_reg_sel(i_reg_sel), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_sleep_insn(i_sleep_insn), .i_ext_wake(i_ext_wake),
        .i_exc_entry(i_exc_entry), .i_ram_range(i_ram_range), .i_periph_range(i_periph_range),
        .i_ext_range(i_ext_range), .i_ext_area(i_ext_area), .i_area_wide(i_area_wide),
        .i_area_three(i_area_three), .i_port_dir(i_port_dir), .o_reg_rdata(o_reg_rdata),
        .o_reg_ack(o_reg_ack), .o_access_states(o_access_states),
        .o_access_wide(o_access_wide), .o_ram_active(o_ram_active),
        .o_ram_read_fill(o_ram_read_fill), .o_ext_access(o_ext_access),
        .o_addr_64k(o_addr_64k), .o_port3_databus(o_port3_databus),
        .o_port_addr_en(o_port_addr_en), .o_set_int_mask(o_set_int_mask),
        .o_set_user_or_mask_flag(o_set_user_or_mask_flag),
        .o_user_flag_is_mask(o_user_flag_is_mask),
        .o_nonmaskable_rising(o_nonmaskable_rising), .o_clock_halted(o_clock_halted),
        .o_core_stopped(o_core_stopped));

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bit 8 of a note asks for a data comparison; writes only expect the ack.
    task automatic reg_acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                           input logic [8:0] nt);
        exp_q.push_back(nt);
        i_reg_sel = 1'b1;
        i_reg_wr = wr;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(posedge i_clk);
        #1;
        i_reg_sel = 1'b0;
        i_reg_wr = 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    always @(posedge i_clk) begin
        if (o_reg_ack === 1'b1) begin
            chk(exp_q.size() > 0, "ack without request");
            if (exp_q.size() > 0) begin
                note = exp_q.pop_front();
                chk(!note[8] || o_reg_rdata === note[7:0], "read data");
            end
        end
    end

    task automatic acc(input logic r, input logic p, input logic e, input logic [2:0] ar);
        i_ram_range = r;
        i_periph_range = p;
        i_ext_range = e;
        i_ext_area = ar;
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    task automatic pulse_exc(input logic um);
        i_exc_entry = 1'b1;
        @(posedge i_clk);
        #1;
        i_exc_entry = 1'b0;
        chk(o_set_int_mask === 1'b1, "mask set on entry");
        chk(o_set_user_or_mask_flag === um, "user flag on entry");
    endtask

    task automatic pulse_pwr(input logic wake);
        i_sleep_insn = !wake;
        i_ext_wake = wake;
        @(posedge i_clk);
        #1;
        i_sleep_insn = 1'b0;
        i_ext_wake = 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    initial begin
        #(50 * 40000);
        n_mismatch++;
        end_sim();
    end

    initial begin
        seed_v = $urandom(32'h42FFA2D3);
        for (int m = 1; m <= 3; m++) begin
            mode_req = 2'(m);
            i_rst = 1'b1;
            i_port_dir = 8'($urandom);
            i_area_wide = 8'($urandom);
            i_area_three = 8'($urandom);
            repeat (10) @(posedge i_clk);
            #1;
            i_rst = 1'b0;
            reg_acc(1'b0, `MC_ADDR_SYS_CTRL, 8'h00, {1'b1, `MC_SYS_CTRL_RESET});
            reg_acc(1'b0, `MC_ADDR_MODE_STATUS, 8'h00, {1'b1, 6'h31, 2'(m)});
            reg_acc(1'b1, `MC_ADDR_MODE_STATUS, 8'h3B, 9'h000);
            reg_acc(1'b0, `MC_ADDR_MODE_STATUS, 8'h00, {1'b1, 6'h31, 2'(m)});
            reg_acc(1'b0, 16'hFFF0, 8'h00, 9'h100);
            wv = 8'($urandom) & 8'hBF;
            reg_acc(1'b1, `MC_ADDR_SYS_CTRL, wv, 9'h000);
            reg_acc(1'b0, `MC_ADDR_SYS_CTRL, 8'h00, {1'b1, wv | 8'h02});
            reg_acc(1'b1, `MC_ADDR_SYS_CTRL, 8'h0A, 9'h000);
            acc(1'b1, 1'b0, 1'b0, 3'h0);
            chk(o_ram_active === 1'b0, "ram off");
            chk(o_ext_access === (m == 1), "ram range external");
            chk(o_ram_read_fill === (m != 1), "ram fill");
            reg_acc(1'b1, `MC_ADDR_SYS_CTRL, 8'h0F, 9'h000);
            chk(o_nonmaskable_rising === 1'b1 && o_user_flag_is_mask === 1'b0, "flags");
            acc(1'b1, 1'b0, 1'b0, 3'h0);
            chk(o_ram_active === 1'b1 && o_access_states === `MC_MEM_STATES, "ram");
            chk(o_access_wide === 1'b1, "ram path width");
            acc(1'b0, 1'b1, 1'b0, 3'h0);
            chk(o_access_states === `MC_PERIPH_STATES, "peripheral states");
            acc(1'b0, 1'b0, 1'b1, 3'($urandom));
            chk(o_ext_access === (m == 1), "external access");
            if (m == 1) begin
                chk(o_access_wide === i_area_wide[i_ext_area], "area width");
                chk(o_access_states === (i_area_three[i_ext_area] ? 2'h3 : 2'h2), "area");
            end
            chk(o_addr_64k === (m == 2) && o_port3_databus === (m == 1), "mode map");
            chk(o_port_addr_en === (m == 1 ? i_port_dir : 8'h00), "port address");
            acc(1'b0, 1'b0, 1'b0, 3'h0);
            pulse_exc(1'b0);
            reg_acc(1'b1, `MC_ADDR_SYS_CTRL, 8'h03, 9'h000);
            chk(o_user_flag_is_mask === 1'b1 && o_nonmaskable_rising === 1'b0, "mask");
            pulse_exc(1'b1);
            $display("test mode %0d done", m);
        end
        pulse_pwr(1'b0);
        chk(o_core_stopped === 1'b1 && o_clock_halted === 1'b0, "sleep");
        pulse_pwr(1'b1);
        chk(o_core_stopped === 1'b0, "sleep wake");
        reg_acc(1'b1, `MC_ADDR_SYS_CTRL, 8'h8B, 9'h000);
        pulse_pwr(1'b0);
        chk(o_clock_halted === 1'b1, "deep standby");
        pulse_pwr(1'b1);
        n = 0;
        while (o_clock_halted === 1'b1 && n < 140000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk(n >= 8190 && n <= 8196, "settle length");
        chk(o_core_stopped === 1'b0, "running after settle");
        reg_acc(1'b0, `MC_ADDR_SYS_CTRL, 8'h00, 9'h18B);
        $display("test power done");
        chk(exp_q.size() == 0, "all accesses answered");
        end_sim();
    end
endmodule
